// ==== can_msg_obj_params.svh ====
// register offsets, field positions and sizes for the message object status and tag block
`ifndef CAN_MSG_OBJ_PARAMS_SVH
`define CAN_MSG_OBJ_PARAMS_SVH
`define OFS_STATUS      8'hb2
`define OFS_TAG1        8'hbc
`define OFS_TAG2        8'hbd
`define OFS_TAG3        8'hbe
`define OFS_TAG4        8'hbf
`define BIT_LEN_WARN    7
`define BIT_TX_DONE     6
`define BIT_RX_DONE     5
`define BIT_BIT_FAULT   4
`define BIT_STUFF_FAULT 3
`define BIT_CRC_FAULT   2
`define BIT_FORM_FAULT  1
`define BIT_ACK_FAULT   0
`define BIT_RTR_TAG     2
`define BIT_RB0_TAG     0
`define NUM_OBJECTS     4
`endif

// ==== can_msg_obj_pkg.sv ====
// types shared by the message object status and tag block
package can_msg_obj_pkg;
  // one event report from the protocol engine about a finished frame
  typedef struct packed {
    logic       valid;      // report present this cycle
    logic       is_tx;      // 1 transmit, 0 receive
    logic [3:0] obj_hits;   // objects concerned (one-hot or several)
    logic       done;       // frame finished cleanly
    logic [3:0] rx_len;     // received length code
    logic [28:0] rx_id;     // received identifier
    logic       rx_ext;     // received frame used extended format
    logic       rx_rtr;     // received remote request bit
    logic       rx_rb0;     // received reserved bit 0
  } frame_report_t;
  // raw error detections from the bit stream
  typedef struct packed {
    logic tx_active;        // node currently transmitting
    logic in_arb;           // inside arbitration field
    logic in_ack_slot;      // inside acknowledge slot
    logic in_err_frame;     // sending an error frame
    logic sent_bit;         // level driven (1 recessive)
    logic mon_bit;          // level seen on bus
    logic bit_strobe;       // sample point of one bit
    logic stuff_region;     // bit is subject to stuffing
    logic crc_mismatch;     // receiver crc compare failed
    logic form_bad;         // delimiter or end-of-frame bad
    logic ack_missing;      // no dominant in ack slot
  } bit_events_t;
  // special-function register access
  typedef struct packed {
    logic       wr;         // write strobe
    logic       rd;         // read strobe
    logic [7:0] addr;       // sfr address
    logic [7:0] wdata;      // write data
  } sfr_req_t;
endpackage : can_msg_obj_pkg

// ==== can_msg_object_status_idtag.sv ====
// per-object status flags and identifier tags of the CAN controller
`include "can_msg_obj_params.svh"
// Overview of operation
// - set length warning on mismatched length; always store received length code
// - set transmit-done in bit 6 when enabled transmission completes
// - lowest enabled object index transmits first
// - set receive-done in bit 5 when enabled reception completes
// - matching frame updates lowest-index receiving object first
// - bit fault in bit 4 on monitored/driven mismatch while transmitting
// - no bit fault for recessive sent, dominant seen in arbitration or ack slot, nor for error-frame dominant
// - stuffing fault in bit 3 after more than five equal bits
// - checksum fault in bit 2 when receiver crc compare fails
// - format fault in bit 1 on bad delimiters or end of frame
// - acknowledge fault in bit 0 when ack slot stays recessive
// - flags stay set until software clears them; bits 6:0 may interrupt, length warning does not
// - status and tag registers have no defined reset content
// - standard id: bits 10:3 in tag 1, bits 2:0 in tag 2 7:5
// - standard: tag 3 reserved; tag 4 holds remote bit 2, rb0 bit 0
// - extended id: 28:21, 20:13, 12:5 in tags 1, 2, 3
// - extension select bit chooses 11-bit or 29-bit layout
// - page object number selects which of objects 0 to 3 is shown
module can_msg_object_status_idtag
  import can_msg_obj_pkg::*;
#(
  parameter int NOBJ = `NUM_OBJECTS
) (
  input  wire logic          ref_clk,        // 200 MHz system clock
  input  wire logic          rstn,           // synchronous reset, active low
  input  wire sfr_req_t      sfr,            // register access from the core
  input  wire logic [1:0]    object_number,  // page register object field
  input  wire logic [NOBJ-1:0] expect_ext,   // per-object extended_format_select
  input  wire logic [NOBJ*4-1:0] expect_len, // per-object expected length code
  input  wire logic [NOBJ-1:0] tx_enabled,   // objects enabled as producers
  input  wire logic          tx_ready,       // engine ready to load a frame
  input  wire frame_report_t rep,            // frame completion report
  input  wire bit_events_t   bev,            // bit level error detections
  output logic [7:0]         sfr_rdata_r,    // read data
  output logic [1:0]         tx_pick_r,      // object chosen for transmission
  output logic               tx_pick_vld_r,  // a transmit object is chosen
  output logic [NOBJ*4-1:0]  len_store_r,    // stored length codes per object
  output logic [NOBJ-1:0]    flag_irq_r      // per-object interrupt source, any of flags 6:0
);
  // ----------------------------------------------------------------
  // storage: no reset on status and tags
  // ----------------------------------------------------------------
  logic [7:0]  status_r [NOBJ];
  logic [28:0] id_r     [NOBJ];
  logic [NOBJ-1:0] rtr_r, rb0_r;
  logic [2:0]  run_r;
  logic        last_bit_r;
  logic [1:0]  tx_obj_r;                   // object owning the current transmission

  // ----------------------------------------------------------------
  // priority pickers
  // ----------------------------------------------------------------
  logic [1:0] tx_low, rx_low;
  logic       tx_any, rx_any;
  always_comb begin
    tx_low = 2'h0;
    rx_low = 2'h0;
    tx_any = 1'b0;
    rx_any = 1'b0;
    for (int i = NOBJ - 1; i >= 0; i--) begin
      if (tx_enabled[i]) begin
        tx_low = 2'(i);
        tx_any = 1'b1;
      end
      if (rep.obj_hits[i]) begin
        rx_low = 2'(i);
        rx_any = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // error detection
  // ----------------------------------------------------------------
  wire bit_mismatch = bev.tx_active && bev.bit_strobe && (bev.sent_bit != bev.mon_bit);
  // recessive sent but dominant seen is legal in arbitration and ack slot
  wire exempt_arb   = (bev.in_arb || bev.in_ack_slot) && bev.sent_bit && !bev.mon_bit;
  wire exempt_err   = bev.in_err_frame && !bev.mon_bit;
  wire bit_fault    = bit_mismatch && !exempt_arb && !exempt_err;
  wire same_bit     = bev.mon_bit == last_bit_r;
  wire stuff_fault  = bev.bit_strobe && bev.stuff_region && same_bit
                      && (run_r == 3'h5);
  wire crc_fault    = bev.crc_mismatch && !bev.tx_active;
  wire form_fault   = bev.form_bad;
  wire ack_fault    = bev.ack_missing;
  wire [1:0] cur_obj = bev.tx_active ? tx_obj_r : rx_low;
  wire [7:0] err_set = {3'h0, bit_fault, stuff_fault, crc_fault, form_fault, ack_fault};

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      run_r      <= 3'h0;
      last_bit_r <= 1'b1;
    end else if (bev.bit_strobe) begin
      last_bit_r <= bev.mon_bit;
      run_r      <= (same_bit && bev.stuff_region) ? ((run_r == 3'h5) ? 3'h1 : run_r + 3'h1)
                                                   : 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  wire wr_stat = sfr.wr && sfr.addr == `OFS_STATUS;
  wire wr_t1   = sfr.wr && sfr.addr == `OFS_TAG1;
  wire wr_t2   = sfr.wr && sfr.addr == `OFS_TAG2;
  wire wr_t3   = sfr.wr && sfr.addr == `OFS_TAG3;
  wire wr_t4   = sfr.wr && sfr.addr == `OFS_TAG4;
  wire [7:0] sel_stat = status_r[object_number];
  wire [28:0] sel_id  = id_r[object_number];
  wire sel_ext        = expect_ext[object_number];
  wire [7:0] tag1 = sel_ext ? sel_id[28:21] : sel_id[10:3];
  wire [7:0] tag2 = sel_ext ? sel_id[20:13] : {sel_id[2:0], 5'h00};
  wire [7:0] tag3 = sel_ext ? sel_id[12:5] : 8'h00;
  wire [7:0] tag4 = {sel_ext ? sel_id[4:0] : 5'h00, rtr_r[object_number], 1'b0,
                     rb0_r[object_number]};
  wire [7:0] rd_mux = (sfr.addr == `OFS_STATUS) ? sel_stat :
                      (sfr.addr == `OFS_TAG1)   ? tag1 :
                      (sfr.addr == `OFS_TAG2)   ? tag2 :
                      (sfr.addr == `OFS_TAG3)   ? tag3 :
                      (sfr.addr == `OFS_TAG4)   ? tag4 : 8'h00;

  // ----------------------------------------------------------------
  // per-object flags and tags
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < NOBJ; i++) begin
      logic [7:0] set_v;
      logic       page;
      set_v = 8'h00;
      page  = (object_number == 2'(i));
      if (rep.valid && rep.done && rep.is_tx && tx_obj_r == 2'(i))
        set_v[`BIT_TX_DONE] = 1'b1;
      if (rep.valid && rep.done && !rep.is_tx && rx_any && rx_low == 2'(i)) begin
        set_v[`BIT_RX_DONE] = 1'b1;
        if (rep.rx_len != expect_len[i*4 +: 4])
          set_v[`BIT_LEN_WARN] = 1'b1;
        id_r[i]  <= rep.rx_id;
        rtr_r[i] <= rep.rx_rtr;
        rb0_r[i] <= rep.rx_rb0;
      end else if (page) begin
        if (wr_t1) id_r[i] <= sel_ext ? {sfr.wdata, id_r[i][20:0]}
                                      : {id_r[i][28:11], sfr.wdata, id_r[i][2:0]};
        if (wr_t2) id_r[i] <= sel_ext ? {id_r[i][28:21], sfr.wdata, id_r[i][12:0]}
                                      : {id_r[i][28:3], sfr.wdata[7:5]};
        if (wr_t3 && sel_ext) id_r[i] <= {id_r[i][28:13], sfr.wdata, id_r[i][4:0]};
        if (wr_t4) begin
          rtr_r[i] <= sfr.wdata[`BIT_RTR_TAG];
          rb0_r[i] <= sfr.wdata[`BIT_RB0_TAG];
        end
      end
      if (cur_obj == 2'(i) && (bev.tx_active || rx_any))
        set_v = set_v | err_set;
      // set wins over a software write in the same cycle
      if (wr_stat && page)
        status_r[i] <= sfr.wdata | set_v;
      else
        status_r[i] <= status_r[i] | set_v;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sfr_rdata_r   <= 8'h00;
      tx_pick_r     <= 2'h0;
      tx_pick_vld_r <= 1'b0;
      tx_obj_r      <= 2'h0;
      len_store_r   <= '0;
      flag_irq_r    <= '0;
    end else begin
      sfr_rdata_r   <= sfr.rd ? rd_mux : sfr_rdata_r;
      tx_pick_vld_r <= tx_ready && tx_any;
      if (tx_ready && tx_any) begin
        tx_pick_r <= tx_low;
        tx_obj_r  <= tx_low;
      end
      if (rep.valid && !rep.is_tx && rx_any)
        len_store_r[rx_low*4 +: 4] <= rep.rx_len;
      for (int i = 0; i < NOBJ; i++)
        flag_irq_r[i] <= |status_r[i][6:0];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // limitation: errors with no transmission and no receive hit belong to
  // no object and are dropped, since no status register could own them
  a_len_store: assert property (@(posedge ref_clk) disable iff (!rstn)
    (rep.valid && !rep.is_tx && rx_any) |=> len_store_r[$past(rx_low)*4 +: 4] == $past(rep.rx_len))
    else $error("length code not stored");
  a_tx_lowest: assert property (@(posedge ref_clk) disable iff (!rstn)
    (tx_ready && tx_enabled[0]) |=> tx_pick_r == 2'h0 && tx_pick_vld_r)
    else $error("object 0 not served first");
  // error flags are checked on the object that owned the frame, not on the
  // paged one, so a page change by software cannot hide a missing set
  a_stuff_flag: assert property (@(posedge ref_clk) disable iff (!rstn)
    (stuff_fault && (bev.tx_active || rx_any))
      |=> status_r[$past(cur_obj)][`BIT_STUFF_FAULT])
    else $error("stuffing fault not flagged");

  a_tx_done_set: assert property (@(posedge ref_clk) disable iff (!rstn)
    (rep.valid && rep.done && rep.is_tx)
      |=> status_r[$past(tx_obj_r)][`BIT_TX_DONE])
    else $error("transmit done not flagged");

  a_rx_done_set: assert property (@(posedge ref_clk) disable iff (!rstn)
    (rep.valid && rep.done && !rep.is_tx && rx_any)
      |=> status_r[$past(rx_low)][`BIT_RX_DONE])
    else $error("receive done not flagged");

  a_len_warn_set: assert property (@(posedge ref_clk) disable iff (!rstn)
    (rep.valid && rep.done && !rep.is_tx && rx_any
      && rep.rx_len != expect_len[rx_low*4 +: 4])
      |=> status_r[$past(rx_low)][`BIT_LEN_WARN])
    else $error("length warning not flagged");

  a_rx_lowest: assert property (@(posedge ref_clk) disable iff (!rstn)
    (rep.valid && !rep.is_tx && rep.obj_hits[0])
      |=> len_store_r[3:0] == $past(rep.rx_len))
    else $error("object 0 not updated first");

  a_bit_fault_set: assert property (@(posedge ref_clk) disable iff (!rstn)
    bit_fault |=> status_r[$past(tx_obj_r)][`BIT_BIT_FAULT])
    else $error("bit fault not flagged");

  a_err_exempt: assert property (@(posedge ref_clk) disable iff (!rstn)
    (bev.in_err_frame && !bev.mon_bit) |-> !bit_fault)
    else $error("bit fault during error frame");

  a_crc_set: assert property (@(posedge ref_clk) disable iff (!rstn)
    (crc_fault && rx_any) |=> status_r[$past(rx_low)][`BIT_CRC_FAULT])
    else $error("checksum fault not flagged");

  a_form_set: assert property (@(posedge ref_clk) disable iff (!rstn)
    (form_fault && (bev.tx_active || rx_any))
      |=> status_r[$past(cur_obj)][`BIT_FORM_FAULT])
    else $error("format fault not flagged");

  a_ack_set: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ack_fault && (bev.tx_active || rx_any))
      |=> status_r[$past(cur_obj)][`BIT_ACK_FAULT])
    else $error("acknowledge fault not flagged");

  a_pick_valid: assert property (@(posedge ref_clk) disable iff (!rstn)
    (tx_ready && tx_any) |=> tx_pick_vld_r)
    else $error("transmit pick not reported");

  a_page_read: assert property (@(posedge ref_clk) disable iff (!rstn)
    (sfr.rd && sfr.addr == `OFS_STATUS) |=> sfr_rdata_r == $past(sel_stat))
    else $error("paged status not read back");
  a_arb_exempt: assert property (@(posedge ref_clk) disable iff (!rstn)
    (bev.in_arb && bev.sent_bit && !bev.mon_bit) |-> !bit_fault)
    else $error("bit fault in arbitration");
  a_flag_sticky: assert property (@(posedge ref_clk) disable iff (!rstn)
    (status_r[1][`BIT_ACK_FAULT] && !(wr_stat && object_number == 2'h1))
      |=> status_r[1][`BIT_ACK_FAULT])
    else $error("flag lost without clear");
endmodule : can_msg_object_status_idtag

// ==== can_far_node.sv ====
// far-side CAN node model feeding frame reports and bit events
module can_far_node
  import can_msg_obj_pkg::*;
(
  input  wire logic ref_clk, // system clock
  output frame_report_t rep, // frame completion report
  output bit_events_t   bev  // bit level detections
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rep = '0;
    bev = '0;
  end
  // report pulses for one cycle only; all fields return to zero with valid, as obj_hits is decoded without valid
  task automatic frame(input logic tx, input logic [3:0] hits, input logic [3:0] len,
                       input logic [28:0] id, input logic ok);
    @(posedge ref_clk);
    #1 rep = '{1'b1, tx, hits, ok, len, id, 1'b0, 1'b1, 1'b1};
    @(posedge ref_clk);
    #1 rep = '0;
  endtask : frame
  task automatic bits(input bit_events_t e, input logic [3:0] n);
    repeat (n) begin
      @(posedge ref_clk);
      #1 bev = e;
    end
    @(posedge ref_clk);
    #1 bev = '0;
  endtask : bits
endmodule : can_far_node

// ==== tb_can_msg_object_status_idtag.sv ====
// testbench for the message object status and tag block
module tb_can_msg_object_status_idtag;
  import can_msg_obj_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    bit_events_t e;
    logic [3:0]  n;
    logic [7:0]  s;
  } row_t;
  logic ref_clk, rstn, tx_ready, tx_pick_vld_r;
  logic [1:0] object_number, tx_pick_r;
  logic [3:0] expect_ext, tx_enabled, flag_irq_r;
  logic [15:0] expect_len, len_store_r;
  logic [7:0] sfr_rdata_r;
  sfr_req_t sfr;
  frame_report_t rep;
  bit_events_t bev;
  int fails, samples_checked;
  logic [7:0] tstd [4] = '{8'hb4, 8'ha0, 8'h00, 8'h05};
  logic [7:0] text [4] = '{8'hd5, 8'he6, 8'hf7, 8'had};
  // stuff pair straddles the five-bit boundary; then the bit fault exceptions, a bit fault, a format fault and an acknowledge fault
  row_t rows [8] = '{'{11'h478, 4'd5, 8'h00}, '{11'h478, 4'd6, 8'h08},
                     '{11'h650, 4'd1, 8'h00}, '{11'h550, 4'd1, 8'h00},
                     '{11'h4d0, 4'd1, 8'h00}, '{11'h450, 4'd1, 8'h10},
                     '{11'h402, 4'd1, 8'h02}, '{11'h401, 4'd1, 8'h01}};
  can_msg_object_status_idtag u_can_msg_object_status_idtag (
    .ref_clk(ref_clk), .rstn(rstn), .sfr(sfr), .object_number(object_number),
    .expect_ext(expect_ext), .expect_len(expect_len), .tx_enabled(tx_enabled),
    .tx_ready(tx_ready), .rep(rep), .bev(bev), .sfr_rdata_r(sfr_rdata_r),
    .tx_pick_r(tx_pick_r), .tx_pick_vld_r(tx_pick_vld_r),
    .len_store_r(len_store_r), .flag_irq_r(flag_irq_r));
  can_far_node u_can_far_node (.ref_clk(ref_clk), .rep(rep), .bev(bev));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // ------------------------------------------------------------------
  // bus cycles and compares
  // ------------------------------------------------------------------
  task automatic sfr_cyc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1 sfr = '{w, ~w, a, d};
    @(posedge ref_clk);
    #1 sfr = '0;
  endtask : sfr_cyc
  task automatic chk(input logic [7:0] a, input logic [7:0] exp);
    sfr_cyc(1'b0, a, 8'h00);
    samples_checked++;
    if (sfr_rdata_r !== exp) begin
      fails++;
      $display("wrong value t=%0t addr %h got %h exp %h", $time, a, sfr_rdata_r, exp);
    end
  endtask : chk
  task automatic chk_pin(input logic [20:0] got, input logic [20:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value t=%0t pins got %h exp %h", $time, got, exp);
    end
  endtask : chk_pin
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  // ------------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------------
  initial begin
    #50000;
    fails++;
    close_out();
  end
  initial begin
    rstn = 1'b0;
    sfr = '0;
    object_number = 2'd0;
    expect_ext = 4'h0;
    expect_len = 16'h8800;
    tx_enabled = 4'b1010;
    tx_ready = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk_pin({tx_pick_vld_r, flag_irq_r, len_store_r}, 21'h0);
    rstn = 1'b1;
    // status has no reset value, so every object is cleared first
    for (int o = 0; o < 4; o++) begin
      object_number = o[1:0];
      sfr_cyc(1'b1, 8'hb2, 8'h00);
    end
    tx_ready = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 chk_pin({tx_pick_vld_r, 18'h0, tx_pick_r}, {1'b1, 18'h0, 2'd1});
    tx_ready = 1'b0;
    object_number = 2'd1;
    u_can_far_node.frame(1'b1, 4'h0, 4'h0, 29'h0, 1'b1);
    @(posedge ref_clk);
    #1 chk_pin({17'h0, flag_irq_r}, 21'h2);
    chk(8'hb2, 8'h40);
    chk(8'hb2, 8'h40);
    foreach (rows[i]) begin
      sfr_cyc(1'b1, 8'hb2, 8'h00);
      u_can_far_node.bits(rows[i].e, rows[i].n);
      chk(8'hb2, rows[i].s);
    end
    object_number = 2'd2;
    u_can_far_node.frame(1'b0, 4'b1100, 4'h3, 29'h5a5, 1'b1);
    chk_pin({5'h0, len_store_r}, 21'h0300);
    chk(8'hb2, 8'ha0);
    for (int k = 0; k < 4; k++) chk(8'hbc + k[7:0], tstd[k]);
    object_number = 2'd3;
    chk(8'hb2, 8'h00);
    u_can_far_node.frame(1'b0, 4'b1000, 4'h8, 29'h7ff, 1'b1);
    chk(8'hb2, 8'h20);
    object_number = 2'd2;
    expect_ext = 4'b0100;
    u_can_far_node.frame(1'b0, 4'b0100, 4'h8, 29'h1abcdef5, 1'b1);
    for (int k = 0; k < 4; k++) chk(8'hbc + k[7:0], text[k]);
    chk(8'hb2, 8'ha0);
    object_number = 2'd0;
    fork
      u_can_far_node.frame(1'b0, 4'b0001, 4'h0, 29'h0, 1'b0);
      u_can_far_node.bits(bit_events_t'(11'h004), 4'd1);
    join
    chk(8'hb2, 8'h04);
    chk(8'hb3, 8'h00);
    close_out();
  end
endmodule : tb_can_msg_object_status_idtag
